/* File: mirc_irq_ctrl.sv */
// Interrupt request flags, enables, edge selection and vector choice.
// Assumes the CPU accesses registers through a one-port data memory interface
// on core_clk and acknowledges a vector with a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none

module mirc_irq_ctrl (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ext_irq_pin_a,
   input wire logic ext_irq_pin_b,
   input wire logic can_ctrl_irq_out,
   input wire mirc_pkg::mirc_src_type src,
   input wire mirc_pkg::mirc_mem_type mem,
   input wire logic cpu_ack,
   input wire logic [3:0] cpu_ack_vec,
   output logic [7:0] rd_data_ff,
   output logic irq_req_ff,
   output logic [3:0] irq_vec_ff
);

   // ==========================================================================
   // Register storage
   logic [7:0] regs_ff [0:9];
   logic [7:0] set_bits [0:9];
   logic [7:0] clr_bits [0:9];
   logic [7:0] nxt_regs [0:9];

   // ==========================================================================
   // Pin synchronisers; the first stage feeds only the second
   logic [1:0] pin_meta_ff;
   logic [1:0] pin_sync_ff;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_meta_ff <= 2'h0;
         pin_sync_ff <= 2'h0;
      end else begin
         pin_meta_ff <= {ext_irq_pin_b, ext_irq_pin_a};
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // ==========================================================================
   // Edge detection for pin a, pin b and the CAN line
   // The CAN output is on-chip logic on this clock, so it is not synchronised
   wire [2:0] line_lvl = {can_ctrl_irq_out, pin_sync_ff};
   wire [7:0] edge_reg = regs_ff[mirc_pkg::IDX_EDGE_SELECT];
   wire [5:0] edge_sels = {edge_reg[mirc_pkg::EDGE_CAN_LSB +: 2],
                           edge_reg[mirc_pkg::EDGE_PIN_B_LSB +: 2],
                           edge_reg[mirc_pkg::EDGE_PIN_A_LSB +: 2]};
   logic [2:0] line_hit;

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_edge
         mirc_edge_detect u_edge (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .line_lvl(line_lvl[g]),
            .edge_sel(edge_sels[2*g +: 2]),
            .hit(line_hit[g])
         );
      end
   endgenerate

   // ==========================================================================
   // Multi-function summaries: a comparator event only raises its shared
   // flag when that comparator is enabled, so a masked source stays quiet
   logic [4:0] multi_hit;

   generate
      for (g = 0; g < 5; g++) begin : g_multi
         wire [7:0] mreg = regs_ff[g + 5];
         assign multi_hit[g] = (src.tm_cmp_a[g] & mreg[mirc_pkg::MULTI_A_EN]) |
                               (src.tm_cmp_p[g] & mreg[mirc_pkg::MULTI_P_EN]);
      end
   endgenerate

   // ==========================================================================
   // Hardware set bits per register; enables gate only the shared comparator summaries
   always_comb begin
      for (int r = 0; r < mirc_pkg::REG_CNT; r++) begin
         set_bits[r] = 8'h00;
      end
      set_bits[1][mirc_pkg::CTRL0_PIN_A_FLAG] = line_hit[0];
      set_bits[1][mirc_pkg::CTRL0_PIN_B_FLAG] = line_hit[1];
      set_bits[1][mirc_pkg::CTRL0_ADC_FLAG] = src.adc_done;
      set_bits[2][4] = src.uart_event;
      set_bits[2][5] = src.eeprom_event;
      set_bits[2][6] = src.time_base_0;
      set_bits[2][7] = src.time_base_1;
      set_bits[3][7] = line_hit[2];
      set_bits[3][4] = multi_hit[0];
      set_bits[3][5] = multi_hit[1];
      set_bits[3][6] = multi_hit[2];
      set_bits[4][6] = multi_hit[3];
      set_bits[4][7] = multi_hit[4];
      for (int k = 0; k < 5; k++) begin
         set_bits[k + 5][mirc_pkg::MULTI_A_FLAG] = src.tm_cmp_a[k];
         set_bits[k + 5][mirc_pkg::MULTI_P_FLAG] = src.tm_cmp_p[k];
      end
   end

   // ==========================================================================
   // Acknowledge clears: the serviced vector's own flag and the global enable.
   // Comparator flags are never in this table; software clears those.
   always_comb begin
      for (int r = 0; r < mirc_pkg::REG_CNT; r++) begin
         clr_bits[r] = 8'h00;
      end
      if (cpu_ack) begin
         for (int v = 0; v < mirc_pkg::VEC_CNT; v++) begin
            if (cpu_ack_vec == 4'(v)) begin
               clr_bits[mirc_pkg::VEC_REG[v]][mirc_pkg::VEC_FLAG_BIT[v]] = 1'b1;
            end
         end
         clr_bits[1][mirc_pkg::CTRL0_GLOBAL_EN] = 1'b1;
      end
   end

   // ==========================================================================
   // Register update; a hardware set wins over a same-cycle clear or write
   generate
      for (g = 0; g < mirc_pkg::REG_CNT; g++) begin : g_reg
         wire wr_hit = mem.wr_en && (mem.addr == 4'(g));
         wire [7:0] written = wr_hit ? (mem.wdata & mirc_pkg::REG_MASK[g]) : regs_ff[g];
         assign nxt_regs[g] = (written & ~clr_bits[g]) | set_bits[g];

         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               regs_ff[g] <= mirc_pkg::REG_RESET;
            end else begin
               regs_ff[g] <= nxt_regs[g];
            end
         end
      end
   endgenerate

   // ==========================================================================
   // Pending vectors gated by own enable and the global enable
   wire global_en = regs_ff[1][mirc_pkg::CTRL0_GLOBAL_EN];
   logic [12:0] vec_pend;

   generate
      for (g = 0; g < mirc_pkg::VEC_CNT; g++) begin : g_vec
         wire [7:0] vreg = regs_ff[mirc_pkg::VEC_REG[g]];
         assign vec_pend[g] = vreg[mirc_pkg::VEC_FLAG_BIT[g]] &
                              vreg[mirc_pkg::VEC_EN_BIT[g]] & global_en;
      end
   endgenerate

   // ==========================================================================
   // Fixed priority: the lowest-index pending vector wins
   logic nxt_irq_req;
   logic [3:0] nxt_irq_vec;

   always_comb begin
      nxt_irq_req = 1'b0;
      nxt_irq_vec = 4'h0;
      for (int v = mirc_pkg::VEC_CNT - 1; v >= 0; v--) begin
         if (vec_pend[v]) begin
            nxt_irq_req = 1'b1;
            nxt_irq_vec = 4'(v);
         end
      end
   end

   // ==========================================================================
   // Read path; unimplemented bits and unmapped indices read as zero
   wire addr_valid = mem.addr <= mirc_pkg::IDX_MULTI_4;
   wire [7:0] rd_sel = addr_valid ?
                       (regs_ff[mem.addr] & mirc_pkg::REG_MASK[mem.addr]) : 8'h00;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rd_data_ff <= 8'h00;
         irq_req_ff <= 1'b0;
         irq_vec_ff <= 4'h0;
      end else begin
         rd_data_ff <= rd_sel;
         irq_req_ff <= nxt_irq_req;
         irq_vec_ff <= nxt_irq_vec;
      end
   end

endmodule : mirc_irq_ctrl
`default_nettype wire

/* File: mirc_pkg.sv */
// Constants and carrier types for the interrupt request and enable block.
// Assumes a single core clock and a synchronous, active-high reset.
package mirc_pkg;

   // ==========================================================================
   // Register indices on the special-purpose data memory port
   localparam int REG_CNT = 10;
   localparam logic [3:0] IDX_EDGE_SELECT = 4'h0;
   localparam logic [3:0] IDX_CTRL_0 = 4'h1;
   localparam logic [3:0] IDX_CTRL_1 = 4'h2;
   localparam logic [3:0] IDX_CTRL_2 = 4'h3;
   localparam logic [3:0] IDX_CTRL_3 = 4'h4;
   localparam logic [3:0] IDX_MULTI_0 = 4'h5;
   localparam logic [3:0] IDX_MULTI_4 = 4'h9;

   // ==========================================================================
   // Field positions
   localparam int EDGE_PIN_A_LSB = 0;
   localparam int EDGE_PIN_B_LSB = 2;
   localparam int EDGE_CAN_LSB = 4;
   localparam int CTRL0_GLOBAL_EN = 0;
   localparam int CTRL0_PIN_A_EN = 1;
   localparam int CTRL0_PIN_B_EN = 2;
   localparam int CTRL0_ADC_EN = 3;
   localparam int CTRL0_PIN_A_FLAG = 4;
   localparam int CTRL0_PIN_B_FLAG = 5;
   localparam int CTRL0_ADC_FLAG = 6;
   localparam int MULTI_P_EN = 0;
   localparam int MULTI_A_EN = 1;
   localparam int MULTI_P_FLAG = 4;
   localparam int MULTI_A_FLAG = 5;

   // ==========================================================================
   // Edge-select codes
   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // ==========================================================================
   // Reset values and writable / readable masks per register index
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] REG_MASK [0:9] = '{
      8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h33, 8'h33, 8'h33, 8'h33, 8'h33};

   // ==========================================================================
   // Vectors in fixed priority order, index 0 highest
   localparam int VEC_CNT = 13;
   localparam logic [3:0] VEC_REG [0:12] = '{
      4'h1, 4'h1, 4'h3, 4'h3, 4'h3, 4'h3, 4'h1, 4'h4, 4'h4, 4'h2, 4'h2, 4'h2, 4'h2};
   localparam logic [2:0] VEC_FLAG_BIT [0:12] = '{
      3'h4, 3'h5, 3'h7, 3'h4, 3'h5, 3'h6, 3'h6, 3'h6, 3'h7, 3'h4, 3'h5, 3'h6, 3'h7};
   localparam logic [2:0] VEC_EN_BIT [0:12] = '{
      3'h1, 3'h2, 3'h3, 3'h0, 3'h1, 3'h2, 3'h3, 3'h2, 3'h3, 3'h0, 3'h1, 3'h2, 3'h3};

   // ==========================================================================
   // Carrier types
   typedef struct packed {
      logic [4:0] tm_cmp_a;
      logic [4:0] tm_cmp_p;
      logic adc_done;
      logic time_base_0;
      logic time_base_1;
      logic uart_event;
      logic eeprom_event;
   } mirc_src_type;

   typedef struct packed {
      logic wr_en;
      logic [3:0] addr;
      logic [7:0] wdata;
   } mirc_mem_type;

endpackage : mirc_pkg

/* File: mirc_edge_detect.sv */
// Edge detector for one interrupt line with a two-bit sensitivity select.
// Assumes the line is already in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module mirc_edge_detect (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic line_lvl,
   input wire logic [1:0] edge_sel,
   output logic hit
);

   logic prev_ff;
   wire rise = line_lvl & ~prev_ff;
   wire fall = ~line_lvl & prev_ff;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= line_lvl;
      end
   end

   always_comb begin
      case (edge_sel)
         mirc_pkg::EDGE_RISE: hit = rise;
         mirc_pkg::EDGE_FALL: hit = fall;
         mirc_pkg::EDGE_BOTH: hit = rise | fall;
         default: hit = 1'b0;
      endcase
   end

endmodule : mirc_edge_detect
`default_nettype wire

/* File: mirc_props.sv */
// Port checker for mirc_irq_ctrl.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module mirc_props (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ext_irq_pin_a,
   input wire logic ext_irq_pin_b,
   input wire logic can_ctrl_irq_out,
   input wire mirc_pkg::mirc_src_type src,
   input wire mirc_pkg::mirc_mem_type mem,
   input wire logic cpu_ack,
   input wire logic [3:0] cpu_ack_vec,
   input wire logic [7:0] rd_data_ff,
   input wire logic irq_req_ff,
   input wire logic [3:0] irq_vec_ff
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   // ==========
   // Assertions
   a_reset_clears: assert property (disable iff (1'b0)
      sys_rst |=> rd_data_ff == 8'h00 && !irq_req_ff) else $error("reset not clean");
   a_ctrl_top_zero: assert property (
      mem.addr == 4'h1 |=> !rd_data_ff[7]) else $error("ctrl bit 7 set");
   a_multi_gap_zero: assert property (
      mem.addr inside {[4'h5:4'h9]} |=> !(rd_data_ff & 8'hcc)) else $error("gap bits set");
   a_edge_readback: assert property (
      mem.wr_en && mem.addr == 4'h0 ##1 mem.addr == 4'h0 |=> rd_data_ff == $past(mem.wdata, 2))
      else $error("edge readback");
   a_global_off: assert property (
      mem.wr_en && mem.addr == 4'h1 && !mem.wdata[0] |-> ##2 !irq_req_ff) else $error("global off");
   a_adc_flag_set: assert property (
      src.adc_done && mem.addr == 4'h1 ##1 mem.addr == 4'h1 |=> rd_data_ff[6]) else $error("adc");
   a_ack_drops_req: assert property (
      cpu_ack && !mem.wr_en |-> ##2 !irq_req_ff) else $error("ack kept request");
   a_pin_a_first: assert property (
      mem.wr_en && mem.addr == 4'h1 && mem.wdata[4] && mem.wdata[1:0] == 2'h3 && !cpu_ack
      |-> ##2 irq_req_ff && irq_vec_ff == 4'h0) else $error("pin a priority");
   c_adc_vec: cover property (irq_req_ff && irq_vec_ff == 4'h6);
   c_shared_vec: cover property (irq_req_ff && irq_vec_ff == 4'h3);
   c_ack: cover property (cpu_ack);
endmodule : mirc_props
bind mirc_irq_ctrl mirc_props mirc_props_inst (
   .core_clk(core_clk), .sys_rst(sys_rst), .ext_irq_pin_a(ext_irq_pin_a),
   .ext_irq_pin_b(ext_irq_pin_b), .can_ctrl_irq_out(can_ctrl_irq_out), .src(src), .mem(mem),
   .cpu_ack(cpu_ack), .cpu_ack_vec(cpu_ack_vec), .rd_data_ff(rd_data_ff),
   .irq_req_ff(irq_req_ff), .irq_vec_ff(irq_vec_ff));
`default_nettype wire

/* File: mirc_cpu_model.sv */
// CPU core model: takes the pending vector with a one-cycle ack.
// Assumes block outputs settle after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module mirc_cpu_model (
   input wire logic core_clk,
   input wire logic ack_on,
   input wire logic irq_req_ff,
   input wire logic [3:0] irq_vec_ff,
   output logic cpu_ack,
   output logic [3:0] cpu_ack_vec
);
   // ==========
   // Acknowledge
   // Vector is scrambled once released so a stale copy never matches
   initial begin
      cpu_ack = 1'b0;
      cpu_ack_vec = 4'h0;
      forever begin
         @(negedge core_clk);
         if (cpu_ack) begin
            cpu_ack = 1'b0;
            cpu_ack_vec = ~cpu_ack_vec;
         end else if (ack_on && irq_req_ff) begin
            cpu_ack = 1'b1;
            cpu_ack_vec = irq_vec_ff;
         end
      end
   end
endmodule : mirc_cpu_model
`default_nettype wire

/* File: tb.sv */
// Bench for mirc_irq_ctrl; it plays software, pins and sources.
// Assumes the checker is bound in and the CPU model answers only while ack_on is high.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic core_clk, sys_rst, pin_a, pin_b, can_out, ack_on, cpu_ack, irq_req;
   logic [3:0] ack_vec, irq_vec;
   logic [7:0] rd_data;
   mirc_pkg::mirc_src_type src;
   mirc_pkg::mirc_mem_type mem;
   int err_total, checks;
   logic [7:0] ex [0:10] = '{8'h3f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h33, 8'h33, 8'h33, 8'h33,
      8'h33, 8'h00};
   mirc_irq_ctrl mirc_irq_ctrl_inst (.core_clk(core_clk), .sys_rst(sys_rst),
      .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b), .can_ctrl_irq_out(can_out), .src(src),
      .mem(mem), .cpu_ack(cpu_ack), .cpu_ack_vec(ack_vec), .rd_data_ff(rd_data),
      .irq_req_ff(irq_req), .irq_vec_ff(irq_vec));
   mirc_cpu_model mirc_cpu_model_inst (.core_clk(core_clk), .ack_on(ack_on),
      .irq_req_ff(irq_req), .irq_vec_ff(irq_vec), .cpu_ack(cpu_ack), .cpu_ack_vec(ack_vec));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic results;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge core_clk);
      mem = '{1'b1, a, d};
      @(negedge core_clk);
      mem.wr_en = 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(negedge core_clk);
      mem.addr = a;
      @(negedge core_clk);
      chk("register", rd_data, e);
   endtask : rd
   task automatic req(input logic [7:0] e);
      @(negedge core_clk);
      chk("request", {3'h0, irq_req, irq_vec}, e);
   endtask : req
   task automatic pulse(input logic [14:0] s);
      @(negedge core_clk);
      src = s;
      @(negedge core_clk);
      src = '0;
   endtask : pulse
   task automatic ack;
      ack_on = 1'b1;
      repeat (4) @(negedge core_clk);
      ack_on = 1'b0;
   endtask : ack
   initial begin
      {sys_rst, pin_a, pin_b, can_out, ack_on} = 5'h10;
      src = '0;
      mem = '0;
      err_total = 0;
      checks = 0;
      repeat (16) @(negedge core_clk);
      sys_rst = 1'b0;
      for (int i = 0; i < 16; i++) rd(i[3:0], 8'h00);
      for (int i = 0; i < 11; i++) begin
         wr(i[3:0], i == 0 ? 8'h3f : 8'hff);
         rd(i[3:0], ex[i]);
      end
      req(8'h10);
      wr(4'h1, 8'h0f);
      req(8'h12);
      wr(4'h3, 8'h00);
      req(8'h17);
      wr(4'h1, 8'h0e);
      req(8'h00);
      for (int i = 0; i < 10; i++) wr(i[3:0], 8'h00);
      rd(4'h1, 8'h00);
      pulse(15'h001f);
      rd(4'h1, 8'h40);
      rd(4'h2, 8'hf0);
      req(8'h00);
      wr(4'h2, 8'h00);
      wr(4'h1, 8'h49);
      req(8'h16);
      ack();
      rd(4'h1, 8'h08);
      // Pin b vector on its own; the first write also drops the ADC enable left by the ack test
      wr(4'h1, 8'h25);
      req(8'h11);
      wr(4'h1, 8'h00);
      req(8'h00);
      // ==========
      // Pin edge codes, every code on both pins
      for (int c = 0; c < 4; c++) begin
         wr(4'h0, {4'h0, c[1:0], c[1:0]});
         {pin_a, pin_b} = 2'h3;
         repeat (5) @(negedge core_clk);
         rd(4'h1, {2'h0, c[0], c[0], 4'h0});
         wr(4'h1, 8'h00);
         {pin_a, pin_b} = 2'h0;
         repeat (5) @(negedge core_clk);
         rd(4'h1, {2'h0, c[1], c[1], 4'h0});
         wr(4'h1, 8'h00);
      end
      // ==========
      // CAN line, rising only as for an active-high output
      wr(4'h0, 8'h10);
      wr(4'h3, 8'h08);
      wr(4'h1, 8'h01);
      can_out = 1'b1;
      repeat (4) @(negedge core_clk);
      rd(4'h3, 8'h88);
      req(8'h12);
      wr(4'h3, 8'h09);
      can_out = 1'b0;
      repeat (4) @(negedge core_clk);
      rd(4'h3, 8'h09);
      // ==========
      // Shared comparator vectors
      wr(4'h5, 8'h01);
      pulse(15'h4020);
      rd(4'h5, 8'h11);
      rd(4'h9, 8'h20);
      rd(4'h4, 8'h00);
      rd(4'h3, 8'h19);
      req(8'h13);
      ack();
      rd(4'h5, 8'h11);
      rd(4'h3, 8'h09);
      wr(4'h5, 8'h01);
      rd(4'h5, 8'h01);
      results();
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      err_total++;
      results();
   end
endmodule : tb
`default_nettype wire
